// ===== pkg/autoload_pkg.sv
// shared constants and types for the autoload strap and status block
`default_nettype none
package autoload_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRAP_W = 3;

  // register byte offsets
  localparam logic [11:0] OFF_TEST_STATUS = 12'h0cc;
  localparam logic [11:0] OFF_SUBSYS = 12'h0f0;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h100;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h104;

  // field positions in the test and status word
  localparam int unsigned BIT_ORDER_POS = 29;
  localparam int unsigned BIT_FAST_POS = 28;
  localparam int unsigned BIT_NOBYPASS_POS = 27;
  localparam int unsigned BIT_SUCCESS_POS = 26;
  localparam int unsigned BIT_DISABLE_POS = 24;

  // field positions in the subsystem word
  localparam int unsigned VENDOR_LSB = 0;
  localparam int unsigned IDENT_LSB = 16;

  // strap line index per option
  localparam int unsigned STRAP_ORDER = 2;
  localparam int unsigned STRAP_FAST = 1;
  localparam int unsigned STRAP_NOBYPASS = 0;

  // interrupt event bits
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned EV_LOAD_OK = 0;
  localparam int unsigned EV_LOAD_FAIL = 1;

  // values after reset
  localparam logic RST_SUCCESS = 1'b0;
  localparam logic RST_DISABLE = 1'b1;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_SETTLE,
    ST_LAUNCH,
    ST_BUSY,
    ST_LOADED,
    ST_FAILED,
    ST_SKIPPED
  } load_state_type;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [15:0] ident;
    logic [15:0] vendor;
  } subsys_type;

endpackage : autoload_pkg

`default_nettype wire

// ===== verilog/strap_capture.sv
// samples strap pins while reset is held and keeps them afterwards
`timescale 1ns/1ns
`default_nettype none

module strap_capture #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pins,
  output var  logic [WIDTH-1:0] held_q
);

  // pins are not constants, so no async load: sampled on edges inside reset
  // capture during reset
  always_ff @(posedge clk) begin
    if (rst) begin
      held_q <= pins;
    end
  end

endmodule : strap_capture

`default_nettype wire

// ===== verilog/eeprom_autoload_straps.sv
// autoload strap capture, autoload status and subsystem identity registers
// What this block does
// - bit 29 shows serial bit order, one means lsb first, from grant line 2
// - bit 28 shows autoload speed, zero means fast, from grant line 1
// - bit 27 shows bypass option, one means autoload proceeds, from grant line 0
// - bit 26 is one only after a successful autoload, else zero, resets zero
// - reserved bits 31:30 and 25 of the test word read as zero
// - subsystem vendor in 15:0 and identity in 31:16, defaults, autoload may replace
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none

module eeprom_autoload_straps #(
  // arbitrary neutral identity values
  parameter logic [15:0] SUBSYS_VENDOR_DEFAULT = 16'h5a5a,
  parameter logic [15:0] SUBSYS_IDENT_DEFAULT  = 16'ha5a5
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire autoload_pkg::apb_req_type   apb_req,
  output var  logic [31:0]                 prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  input  wire logic [2:0]                  sec_grant_pins,
  output var  logic                        load_start,
  output var  logic                        load_lsb_first,
  output var  logic                        load_fast,
  input  wire logic                        load_word_valid,
  input  wire autoload_pkg::subsys_type    load_word,
  input  wire logic                        load_done,
  input  wire logic                        load_ok,
  output var  logic                        irq
);

  ////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    autoload_pkg::load_state_type fsm;
    logic                         success;
    logic                         disable_flag;
    autoload_pkg::subsys_type     ids;
    autoload_pkg::subsys_type     shadow;
    logic                         shadow_valid;
    logic [1:0]                   irq_status;
    logic [1:0]                   irq_mask;
    logic [31:0]                  rdata;
    logic                         err;
    logic                         start;
  } state_type;

  state_type q;
  state_type d;

  logic [2:0]  straps_q;
  logic        setup_phase;
  logic        access_phase;
  logic        wr_access;
  logic        mapped;
  logic [31:0] test_word;
  logic [1:0]  events;
  logic [1:0]  w1c;

  ////////////////////////////////////////////////////////////////////
  // strap capture

  strap_capture #(
    .WIDTH (autoload_pkg::STRAP_W)
  ) u_straps (
    .clk    (clk),
    .rst    (rst),
    .pins   (sec_grant_pins),
    .held_q (straps_q)
  );

  ////////////////////////////////////////////////////////////////////
  // register views

  always_comb begin
    test_word = 32'h0000_0000;
    test_word[autoload_pkg::BIT_ORDER_POS] = straps_q[autoload_pkg::STRAP_ORDER];
    test_word[autoload_pkg::BIT_FAST_POS] = straps_q[autoload_pkg::STRAP_FAST];
    test_word[autoload_pkg::BIT_NOBYPASS_POS] = straps_q[autoload_pkg::STRAP_NOBYPASS];
    test_word[autoload_pkg::BIT_SUCCESS_POS] = q.success;
    test_word[autoload_pkg::BIT_DISABLE_POS] = q.disable_flag;
    test_word[31:30] = 2'h0;
    test_word[25] = 1'b0;
  end

  assign setup_phase  = apb_req.psel & ~apb_req.penable;
  assign access_phase = apb_req.psel & apb_req.penable;
  assign wr_access    = access_phase & apb_req.pwrite;

  always_comb begin
    case (apb_req.paddr)
      autoload_pkg::OFF_TEST_STATUS: mapped = 1'b1;
      autoload_pkg::OFF_SUBSYS:      mapped = 1'b1;
      autoload_pkg::OFF_IRQ_STATUS:  mapped = 1'b1;
      autoload_pkg::OFF_IRQ_MASK:    mapped = 1'b1;
      default:                       mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // events and interrupt

  // sequencer below raises these for one cycle
  always_comb begin
    events = 2'h0;
    if (q.fsm == autoload_pkg::ST_BUSY && load_done) begin
      events[autoload_pkg::EV_LOAD_OK]   = load_ok;
      events[autoload_pkg::EV_LOAD_FAIL] = ~load_ok;
    end
  end

  assign w1c = (wr_access && apb_req.paddr == autoload_pkg::OFF_IRQ_STATUS)
             ? apb_req.pwdata[1:0] : 2'h0;

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    d.start = 1'b0;

    // autoload sequencer
    case (q.fsm)
      autoload_pkg::ST_SETTLE: begin
        // straps are valid from the first cycle after release
        if (straps_q[autoload_pkg::STRAP_NOBYPASS]) begin
          d.fsm          = autoload_pkg::ST_LAUNCH;
          d.disable_flag = 1'b0;
        end else begin
          d.fsm = autoload_pkg::ST_SKIPPED;
        end
      end
      autoload_pkg::ST_LAUNCH: begin
        d.start = 1'b1;
        d.fsm   = autoload_pkg::ST_BUSY;
      end
      autoload_pkg::ST_BUSY: begin
        // words held aside until done, so a failed load keeps defaults
        if (load_word_valid) begin
          d.shadow       = load_word;
          d.shadow_valid = 1'b1;
        end
        if (load_done) begin
          if (load_ok) begin
            d.success = 1'b1;
            d.fsm     = autoload_pkg::ST_LOADED;
            // autoload replaces identity only when it succeeds
            if (q.shadow_valid) begin
              d.ids = q.shadow;
            end
            if (load_word_valid) begin
              d.ids = load_word;
            end
          end else begin
            d.fsm = autoload_pkg::ST_FAILED;
          end
        end
      end
      // end states hold until the next reset
      autoload_pkg::ST_LOADED: d.fsm = autoload_pkg::ST_LOADED;
      autoload_pkg::ST_FAILED: d.fsm = autoload_pkg::ST_FAILED;
      // bypass leaves success low and disable high
      autoload_pkg::ST_SKIPPED: d.fsm = autoload_pkg::ST_SKIPPED;
      default: d.fsm = autoload_pkg::ST_SETTLE;
    endcase

    // a set in the clearing cycle wins
    d.irq_status = (q.irq_status & ~w1c) | events;

    if (wr_access && apb_req.paddr == autoload_pkg::OFF_IRQ_MASK) begin
      d.irq_mask = apb_req.pwdata[1:0];
    end

    // read data captured in setup so it leaves a flip-flop
    if (setup_phase) begin
      d.err = ~mapped;
      case (apb_req.paddr)
        autoload_pkg::OFF_TEST_STATUS: d.rdata = test_word;
        autoload_pkg::OFF_SUBSYS:      d.rdata = q.ids;
        autoload_pkg::OFF_IRQ_STATUS:  d.rdata = {30'h0, q.irq_status};
        autoload_pkg::OFF_IRQ_MASK:    d.rdata = {30'h0, q.irq_mask};
        default:                       d.rdata = autoload_pkg::RST_RDATA;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q.fsm          <= autoload_pkg::ST_SETTLE;
      q.success      <= autoload_pkg::RST_SUCCESS;
      q.disable_flag <= autoload_pkg::RST_DISABLE;
      q.ids          <= {SUBSYS_IDENT_DEFAULT, SUBSYS_VENDOR_DEFAULT};
      q.shadow       <= {SUBSYS_IDENT_DEFAULT, SUBSYS_VENDOR_DEFAULT};
      q.shadow_valid <= 1'b0;
      q.irq_status   <= autoload_pkg::RST_IRQ;
      q.irq_mask     <= autoload_pkg::RST_IRQ;
      q.rdata        <= autoload_pkg::RST_RDATA;
      q.err          <= 1'b0;
      q.start        <= 1'b0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  // zero wait states: every access completes in its first access cycle
  assign pready         = access_phase;
  // unmapped offsets flag an error but never stall the bus
  assign pslverr        = access_phase & q.err;
  assign prdata         = q.rdata;
  assign load_start     = q.start;
  assign load_lsb_first = straps_q[autoload_pkg::STRAP_ORDER];
  assign load_fast      = ~straps_q[autoload_pkg::STRAP_FAST];
  // level output: stays high until software clears or masks
  assign irq            = |(q.irq_status & q.irq_mask);

endmodule : eeprom_autoload_straps

`default_nettype wire

// ===== tb/autoload_engine_model.sv
// behavioural serial autoload engine answering the start pulse
`timescale 1ns/1ns
`default_nettype none
module autoload_engine_model #(
  parameter int unsigned DELAY = 6,
  parameter logic [31:0] WORD  = 32'h1357_2468
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     load_start,
  input  wire logic                     ok_mode,
  output var  logic                     load_word_valid,
  output var  autoload_pkg::subsys_type load_word,
  output var  logic                     load_done,
  output var  logic                     load_ok
);
  int unsigned cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_q <= 0;
    else if (load_start) cnt_q <= DELAY;
    else if (cnt_q != 0) cnt_q <= cnt_q - 1;
  end
  assign load_word_valid = cnt_q == 2;
  assign load_done = cnt_q == 1;
  // idle lines show the inverse so stale data never passes
  assign load_word = load_word_valid ? WORD : ~WORD;
  assign load_ok = load_done ? ok_mode : !ok_mode;
endmodule : autoload_engine_model
`default_nettype wire

// ===== tb/eeprom_autoload_straps_checker.sv
// port assertions for the autoload strap and status block
`timescale 1ns/1ns
`default_nettype none
module eeprom_autoload_straps_checker (
  input wire logic                      clk,
  input wire logic                      rst,
  input wire autoload_pkg::apb_req_type apb_req,
  input wire logic [31:0]               prdata,
  input wire logic                      pslverr,
  input wire logic                      load_start,
  input wire logic                      load_lsb_first,
  input wire logic                      load_fast,
  input wire logic                      load_done,
  input wire logic                      load_ok,
  input wire logic                      irq
);
  logic ok_q, st_q, acc, rd_cc;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  assign acc = apb_req.psel && apb_req.penable;
  assign rd_cc = acc && apb_req.paddr == autoload_pkg::OFF_TEST_STATUS;
  // history of good loads and launches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ok_q <= 1'b0;
      st_q <= 1'b0;
    end else begin
      ok_q <= ok_q || (load_done && load_ok);
      st_q <= st_q || load_start;
    end
  end
  ////////////////////////////////////////
  a_order_bit: assert property (rd_cc |-> prdata[29] == load_lsb_first)
    else $error("order bit differs from lsb output");
  a_speed_bit: assert property (rd_cc |-> prdata[28] == !load_fast)
    else $error("speed bit differs from fast output");
  a_bypass_nostart: assert property (rd_cc && !prdata[27] |-> !st_q)
    else $error("load launched while bypassed");
  a_success_cause: assert property (rd_cc && prdata[26] |-> ok_q)
    else $error("success without good load");
  a_reserved_zero: assert property (rd_cc |-> prdata[31:30] == 2'h0 && !prdata[25])
    else $error("reserved bits not zero");
  a_ids_noerr: assert property (acc && apb_req.paddr == autoload_pkg::OFF_SUBSYS |-> !pslverr)
    else $error("ident read flagged error");
  a_strap_held: assert property (!$past(rst) |-> $stable({load_lsb_first, load_fast}))
    else $error("straps changed outside reset");
  a_start_pulse: assert property (load_start |=> !load_start [*3])
    else $error("start not a single pulse");
  cover property (load_start);
  cover property (irq);
  cover property (rd_cc && prdata[26]);
endmodule : eeprom_autoload_straps_checker
`default_nettype wire

// ===== tb/eeprom_autoload_straps_tb.sv
// self-checking bench for the autoload strap and status block
`timescale 1ns/1ns
`default_nettype none
module eeprom_autoload_straps_tb;
  localparam logic [31:0] WORD = 32'h1357_2468;
  localparam logic [31:0] DEFS = 32'ha5a5_5a5a;
  localparam logic [11:0] TS   = autoload_pkg::OFF_TEST_STATUS;
  localparam logic [11:0] SS   = autoload_pkg::OFF_SUBSYS;
  localparam logic [11:0] IS   = autoload_pkg::OFF_IRQ_STATUS;
  logic                      clk, rst, ok_mode, pready, pslverr, start, wv, done, ok, irq, er;
  logic                      lsb, fast;
  logic [2:0]                pins;
  logic [31:0]               prdata, rd;
  autoload_pkg::apb_req_type req;
  autoload_pkg::subsys_type  word;
  int                        fails, n_checks, cycles;
  eeprom_autoload_straps i_dut (.clk(clk), .rst(rst), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sec_grant_pins(pins), .load_start(start),
    .load_lsb_first(lsb), .load_fast(fast), .load_word_valid(wv), .load_word(word),
    .load_done(done), .load_ok(ok), .irq(irq));
  autoload_engine_model #(.WORD(WORD)) i_eng (.clk(clk), .rst(rst), .load_start(start),
    .ok_mode(ok_mode), .load_word_valid(wv), .load_word(word), .load_done(done), .load_ok(ok));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // pins flip after release to show they are not followed
  task automatic do_reset(input logic [2:0] s);
    rst <= 1'b1;
    pins <= s;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    pins <= ~s;
    @(posedge clk);
  endtask : do_reset
  task automatic wait_load();
    for (int i = 0; i < 20; i++) begin
      apb(IS, 1'b0, 32'h0);
      if (rd != 32'h0) break;
    end
  endtask : wait_load
  ////////////////////////////////////////
  // straps across resets
  task automatic t_straps(input logic [2:0] s);
    do_reset(s);
    if (s[0]) wait_load();
    apb(TS, 1'b1, 32'hffff_ffff);
    apb(TS, 1'b0, 32'h0);
    check(rd, {2'h0, s, s[0], 1'b0, ~s[0], 24'h0});
    check({30'h0, lsb, fast}, {30'h0, s[2], ~s[1]});
    apb(SS, 1'b0, 32'h0);
    check(rd, s[0] ? WORD : DEFS);
  endtask : t_straps
  task automatic t_fail();
    ok_mode <= 1'b0;
    do_reset(3'h7);
    wait_load();
    check(rd, 32'h2);
    apb(TS, 1'b0, 32'h0);
    check(rd, 32'h3800_0000);
    apb(SS, 1'b0, 32'h0);
    check(rd, DEFS);
    ok_mode <= 1'b1;
  endtask : t_fail
  task automatic t_irq();
    do_reset(3'h7);
    wait_load();
    check({31'h0, irq}, 32'h0);
    apb(autoload_pkg::OFF_IRQ_MASK, 1'b1, 32'h1);
    check({31'h0, irq}, 32'h1);
    apb(autoload_pkg::OFF_IRQ_MASK, 1'b0, 32'h0);
    check(rd, 32'h1);
    apb(IS, 1'b1, 32'h1);
    check({31'h0, irq}, 32'h0);
    apb(IS, 1'b0, 32'h0);
    check(rd, 32'h0);
  endtask : t_irq
  task automatic t_unmapped();
    apb(12'h0c8, 1'b1, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(12'h0c8, 1'b0, 32'h0);
    check({rd[31:1], er}, 32'h1);
  endtask : t_unmapped
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // cut a hang well beyond the expected few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    rst = 1'b1;
    req = '0;
    pins = 3'h0;
    ok_mode = 1'b1;
    for (int s = 0; s < 8; s++) t_straps(3'(s));
    t_fail();
    t_irq();
    t_unmapped();
    give_verdict();
  end
endmodule : eeprom_autoload_straps_tb
bind eeprom_autoload_straps eeprom_autoload_straps_checker i_chk (.clk(clk), .rst(rst),
  .apb_req(apb_req), .prdata(prdata), .pslverr(pslverr), .load_start(load_start),
  .load_lsb_first(load_lsb_first), .load_fast(load_fast), .load_done(load_done),
  .load_ok(load_ok), .irq(irq));
`default_nettype wire
